// *** fei_almost_flags.sv ***
// Almost-full and almost-empty flag generation for one FIFO
`timescale 1ns/10ps
module fei_almost_flags #(
   parameter int DEPTH = fei_pkg::FIFO_DEPTH_DEF,
   parameter int CNT_W = fei_pkg::CNT_W_DEF
) (
   input  wire logic                       clock_i,
   input  wire logic                       rst_n_i,
   input  wire logic [CNT_W-1:0]           count_i,
   input  wire logic [fei_pkg::VAL_W-1:0]  af_value_i,
   input  wire logic [fei_pkg::VAL_W-1:0]  ae_value_i,
   output logic                            almost_full_o,
   output logic                            almost_empty_o
);
   import fei_pkg::*;

   typedef struct packed {
      logic af;
      logic ae;
   } fei_flag_s;

   fei_flag_s  state_reg;
   fei_flag_s  state_next;

   logic [CNT_W+1:0] fill_plus_af;

   if (CNT_W < VAL_W || DEPTH < 1 || DEPTH >= (2 ** CNT_W) + 1) begin : g_bad
      $error("fei_almost_flags: count width cannot hold the FIFO depth");
   end

   // Sum form avoids underflow when the almost-full value exceeds depth
   always_comb begin
      fill_plus_af     = (CNT_W+2)'(count_i) + (CNT_W+2)'(af_value_i);
      state_next.af    = fill_plus_af >= (CNT_W+2)'(DEPTH);
      state_next.ae    = (CNT_W+1)'(count_i) <= (CNT_W+1)'(ae_value_i);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign almost_full_o  = state_reg.af;
   assign almost_empty_o = state_reg.ae;

endmodule

// *** fei_bridge_model.sv ***
// Model of the bridge chip's local interrupt input
`timescale 1ns/10ps
module fei_bridge_model (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic irq_i,
   input  wire logic lint_en_i,
   output logic      host_irq_o
);
   // Registered, so the host sees the request one cycle late
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) host_irq_o <= 1'b0;
      else host_irq_o <= irq_i & lint_en_i;
   end
endmodule

// *** fei_edge_detect.sv ***
// Per-source edge detector with selectable polarity
`timescale 1ns/10ps
module fei_edge_detect #(
   parameter int WIDTH = fei_pkg::NUM_SRC
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] level_i,
   input  wire logic [WIDTH-1:0] falling_sel_i,
   output logic      [WIDTH-1:0] event_o
);
   import fei_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] prev;
   } fei_edge_s;

   fei_edge_s state_reg;
   fei_edge_s state_next;

   if (WIDTH < 1) begin : g_bad
      $error("fei_edge_detect: width must be at least one");
   end

   always_comb begin
      state_next.prev = level_i;
   end

   // Each bit compares with its own value one clock earlier
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign event_o[i] = falling_sel_i[i] ? (state_reg.prev[i] & ~level_i[i])
                                           : (~state_reg.prev[i] & level_i[i]);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

// *** fei_irq_ctrl.sv ***
// FIFO flag edge interrupt controller, top level
//
// Contract
// - Thirty-two interrupt sources, each enabled on its own.
// - Bit n of every interrupt register belongs to source n.
// - Sources 0,4,8,12 reserved; per channel almost, spare and full/empty sources.
// - Rising fires on false to true, falling on true to false; rising default.
// - Trigger kind register is read only and reports every source edge triggered.
// - Polarity register picks rising or falling detection per source.
// - Enable one allows a source; a disabled source never interrupts.
// - Selected edge on enabled source latches; write one or disable releases.
// - Writing one for a disabled or unlatched source changes nothing.
// - All latched enabled sources merge into one request output.
// - Almost full at size minus value or more; almost empty within value.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module fei_irq_ctrl #(
   parameter int FIFO_DEPTH = fei_pkg::FIFO_DEPTH_DEF,
   parameter int CNT_W      = fei_pkg::CNT_W_DEF
) (
   input  wire logic                                      clock_i,
   input  wire logic                                      rst_n_i,
   input  wire logic [fei_pkg::ADDR_W-1:0]                reg_addr_i,
   input  wire logic [fei_pkg::DATA_W-1:0]                reg_wdata_i,
   input  wire logic                                      reg_wr_i,
   input  wire logic                                      reg_rd_i,
   output logic      [fei_pkg::DATA_W-1:0]                reg_rdata_o,
   input  wire logic [fei_pkg::NUM_CH-1:0][CNT_W-1:0]     tx_count_i,
   input  wire logic [fei_pkg::NUM_CH-1:0][CNT_W-1:0]     rx_count_i,
   input  wire logic [fei_pkg::NUM_CH-1:0]                tx_empty_i,
   input  wire logic [fei_pkg::NUM_CH-1:0]                tx_full_i,
   input  wire logic [fei_pkg::NUM_CH-1:0]                rx_empty_i,
   input  wire logic [fei_pkg::NUM_CH-1:0]                rx_full_i,
   input  wire logic [fei_pkg::NUM_CH-1:0]                aux_receive_line_i,
   output logic                                           irq_o
);
   import fei_pkg::*;

   typedef struct packed {
      logic [NUM_SRC-1:0]             enable;
      logic [NUM_SRC-1:0]             latched;
      logic [NUM_SRC-1:0]             polarity;
      logic [NUM_CH-1:0][DATA_W-1:0]  tx_almost;
      logic [NUM_CH-1:0][DATA_W-1:0]  rx_almost;
      logic [DATA_W-1:0]              rdata;
      logic                           irq;
   } fei_ctrl_s;

   fei_ctrl_s state_reg;
   fei_ctrl_s state_next;

   logic [NUM_CH-1:0]  tx_almost_empty;
   logic [NUM_CH-1:0]  rx_almost_full;
   logic [NUM_SRC-1:0] src_level;
   logic [NUM_SRC-1:0] src_event;
   logic [NUM_SRC-1:0] clear_mask;
   logic [NUM_SRC-1:0] set_mask;
   logic               wr_enable;
   logic               wr_latched;
   logic               wr_polar;

   if (NUM_SRC != DATA_W || NUM_CH * SRC_STRIDE * 2 != NUM_SRC) begin : g_bad
      $error("fei_irq_ctrl: source map does not fit the register width");
   end

   // Per channel almost flags and source placement
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      fei_almost_flags #(
         .DEPTH (FIFO_DEPTH),
         .CNT_W (CNT_W)
      ) u_tx_flags (
         .clock_i        (clock_i),
         .rst_n_i        (rst_n_i),
         .count_i        (tx_count_i[c]),
         .af_value_i     (state_reg.tx_almost[c][AF_LSB +: VAL_W]),
         .ae_value_i     (state_reg.tx_almost[c][AE_LSB +: VAL_W]),
         .almost_full_o  (),
         .almost_empty_o (tx_almost_empty[c])
      );

      fei_almost_flags #(
         .DEPTH (FIFO_DEPTH),
         .CNT_W (CNT_W)
      ) u_rx_flags (
         .clock_i        (clock_i),
         .rst_n_i        (rst_n_i),
         .count_i        (rx_count_i[c]),
         .af_value_i     (state_reg.rx_almost[c][AF_LSB +: VAL_W]),
         .ae_value_i     (state_reg.rx_almost[c][AE_LSB +: VAL_W]),
         .almost_full_o  (rx_almost_full[c]),
         .almost_empty_o ()
      );

      // Reserved positions held low so they can never fire
      assign src_level[SRC_LO_BASE + SRC_STRIDE*c]     = 1'b0;
      assign src_level[SRC_LO_BASE + SRC_STRIDE*c + 1] = tx_almost_empty[c];
      assign src_level[SRC_LO_BASE + SRC_STRIDE*c + 2] = rx_almost_full[c];
      assign src_level[SRC_LO_BASE + SRC_STRIDE*c + 3] = aux_receive_line_i[c];
      assign src_level[SRC_HI_BASE + SRC_STRIDE*c]     = tx_empty_i[c];
      assign src_level[SRC_HI_BASE + SRC_STRIDE*c + 1] = tx_full_i[c];
      assign src_level[SRC_HI_BASE + SRC_STRIDE*c + 2] = rx_empty_i[c];
      assign src_level[SRC_HI_BASE + SRC_STRIDE*c + 3] = rx_full_i[c];
   end

   fei_edge_detect #(
      .WIDTH (NUM_SRC)
   ) u_edge (
      .clock_i       (clock_i),
      .rst_n_i       (rst_n_i),
      .level_i       (src_level),
      .falling_sel_i (state_reg.polarity),
      .event_o       (src_event)
   );

   // Register decode, latching and request merge
   always_comb begin
      state_next = state_reg;

      wr_enable  = reg_wr_i && (reg_addr_i == OFF_IRQ_ENABLE);
      wr_latched = reg_wr_i && (reg_addr_i == OFF_IRQ_LATCHED);
      wr_polar   = reg_wr_i && (reg_addr_i == OFF_IRQ_POLAR);

      if (wr_enable) begin
         state_next.enable = reg_wdata_i & ~RESERVED_SRC;
      end
      if (wr_polar) begin
         state_next.polarity = reg_wdata_i & ~RESERVED_SRC;
      end

      // Almost value registers, one pair per channel
      for (int c = 0; c < NUM_CH; c++) begin
         if (reg_wr_i && reg_addr_i == 8'(OFF_TX_ALMOST + c * OFF_CH_STRIDE)) begin
            state_next.tx_almost[c] = reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == 8'(OFF_RX_ALMOST + c * OFF_CH_STRIDE)) begin
            state_next.rx_almost[c] = reg_wdata_i;
         end
      end

      // Write to the trigger kind register is simply dropped
      clear_mask = wr_latched ? reg_wdata_i : '0;
      // Only enabled sources may latch; a new edge beats a same-cycle clear
      set_mask = src_event & state_reg.enable;
      state_next.latched = ((state_reg.latched & ~clear_mask) | set_mask)
                           & state_next.enable;

      // Registered merge keeps the request output glitch free
      state_next.irq = |(state_next.latched & state_next.enable);

      state_next.rdata = READ_NONE;
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFF_IRQ_ENABLE: begin
               state_next.rdata = state_reg.enable;
            end
            OFF_IRQ_LATCHED: begin
               state_next.rdata = state_reg.latched;
            end
            OFF_IRQ_TRIGGER: begin
               state_next.rdata = TRIGGER_ALL_EDGE;
            end
            OFF_IRQ_POLAR: begin
               state_next.rdata = state_reg.polarity;
            end
            OFF_SRC_LEVEL: begin
               state_next.rdata = src_level;
            end
            default: begin
               for (int c = 0; c < NUM_CH; c++) begin
                  if (reg_addr_i == 8'(OFF_TX_ALMOST + c * OFF_CH_STRIDE)) begin
                     state_next.rdata = state_reg.tx_almost[c];
                  end
                  if (reg_addr_i == 8'(OFF_RX_ALMOST + c * OFF_CH_STRIDE)) begin
                     state_next.rdata = state_reg.rx_almost[c];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg.enable    <= ENABLE_RST;
         state_reg.latched   <= LATCHED_RST;
         state_reg.polarity  <= POLAR_RST;
         state_reg.tx_almost <= {NUM_CH{ALMOST_RST}};
         state_reg.rx_almost <= {NUM_CH{ALMOST_RST}};
         state_reg.rdata     <= READ_NONE;
         state_reg.irq       <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata_o = state_reg.rdata;
   assign irq_o       = state_reg.irq;

endmodule

// *** fei_irq_ctrl_checker.sv ***
// Port-level assertions for the FIFO edge interrupt controller
`timescale 1ns/10ps
module fei_irq_ctrl_checker
   import fei_pkg::*;
(
   input wire logic                       clock_i,
   input wire logic                       rst_n_i,
   input wire logic [fei_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [fei_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic                       reg_wr_i,
   input wire logic                       reg_rd_i,
   input wire logic [fei_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic [fei_pkg::NUM_CH-1:0] tx_empty_i,
   input wire logic [fei_pkg::NUM_CH-1:0] tx_full_i,
   input wire logic                       irq_o
);
   // Shadows of the writable masks; reserved bits never stick
   logic [31:0] en_sh;
   logic [31:0] pol_sh;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_sh  <= '0;
         pol_sh <= '0;
      end else if (reg_wr_i && reg_addr_i == OFF_IRQ_ENABLE) begin
         en_sh  <= reg_wdata_i & ~RESERVED_SRC;
      end else if (reg_wr_i && reg_addr_i == OFF_IRQ_POLAR) begin
         pol_sh <= reg_wdata_i & ~RESERVED_SRC;
      end
   end
   default clocking dcb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   trig_read_a : assert property (
      reg_rd_i && reg_addr_i == OFF_IRQ_TRIGGER |=> reg_rdata_o == TRIGGER_ALL_EDGE)
      else $error("trigger kind read wrong");
   rst_quiet_a : assert property (
      $rose(rst_n_i) |-> !irq_o && reg_rdata_o == 32'h0)
      else $error("outputs not quiet after reset");
   en_read_a : assert property (
      reg_rd_i && reg_addr_i == OFF_IRQ_ENABLE |=> reg_rdata_o == $past(en_sh))
      else $error("enable mask read wrong");
   pol_read_a : assert property (
      reg_rd_i && reg_addr_i == OFF_IRQ_POLAR |=> reg_rdata_o == $past(pol_sh))
      else $error("polarity read wrong");
   lat_subset_a : assert property (
      reg_rd_i && reg_addr_i == OFF_IRQ_LATCHED |=> (reg_rdata_o & ~$past(en_sh)) == 0)
      else $error("latched bit for disabled source");
   dis_clear_a : assert property (
      reg_wr_i && reg_addr_i == OFF_IRQ_ENABLE && reg_wdata_i == 0 |=> !irq_o)
      else $error("request stays after disable");
   irq_needs_en_a : assert property (
      irq_o |-> en_sh != 0)
      else $error("request with no source enabled");
   rise_fire_a : assert property (
      !reg_wr_i && en_sh[17] && !pol_sh[17] && $rose(tx_full_i[0]) |=> irq_o)
      else $error("rising edge missed");
   fall_fire_a : assert property (
      !reg_wr_i && en_sh[16] && pol_sh[16] && $fell(tx_empty_i[0]) |=> irq_o)
      else $error("falling edge missed");
endmodule
bind fei_irq_ctrl fei_irq_ctrl_checker u_chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .tx_empty_i(tx_empty_i), .tx_full_i(tx_full_i),
   .irq_o(irq_o));

// *** fei_irq_ctrl_tb_top.sv ***
// Random and corner-case bench for the FIFO edge interrupt controller
`timescale 1ns/10ps
module fei_irq_ctrl_tb_top;
   import fei_pkg::*;
   // Small FIFO keeps almost thresholds reachable
   localparam int DEPTH = 64;
   logic             clock_i = 1'b0;
   logic             rst_n_i = 1'b0;
   logic             reg_wr_i = 1'b0;
   logic             reg_rd_i = 1'b0;
   logic             lint_en = 1'b0;
   logic             irq_o;
   logic             host_irq;
   logic             p;
   logic [7:0]       reg_addr_i = 8'h00;
   logic [31:0]      reg_wdata_i = 32'h0;
   logic [31:0]      reg_rdata_o;
   logic [31:0]      lvl = 32'h0;
   logic [31:0]      rnd = 32'hEDAB41CA;
   logic [31:0]      v, b, e;
   logic [15:0]      ae, af;
   logic [3:0][15:0] txc = {4{16'h0020}};
   logic [3:0][15:0] rxc = {4{16'h0020}};
   int               error_cnt = 0;
   int               num_checks = 0;
   fei_irq_ctrl #(.FIFO_DEPTH(DEPTH), .CNT_W(16)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .tx_count_i(txc), .rx_count_i(rxc),
      .tx_empty_i({lvl[28], lvl[24], lvl[20], lvl[16]}),
      .tx_full_i({lvl[29], lvl[25], lvl[21], lvl[17]}),
      .rx_empty_i({lvl[30], lvl[26], lvl[22], lvl[18]}),
      .rx_full_i({lvl[31], lvl[27], lvl[23], lvl[19]}),
      .aux_receive_line_i({lvl[15], lvl[11], lvl[7], lvl[3]}),
      .irq_o(irq_o));
   fei_bridge_model bridge (.clock_i(clock_i), .rst_n_i(rst_n_i), .irq_i(irq_o),
      .lint_en_i(lint_en), .host_irq_o(host_irq));
   always #2.5 clock_i = ~clock_i;
   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   function automatic logic ae_f(logic [15:0] n, logic [15:0] t);
      return n <= t;
   endfunction
   function automatic logic af_f(logic [15:0] n, logic [15:0] t);
      return 32'(n) + 32'(t) >= DEPTH;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read, then compare in the one cycle the data stands
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(negedge clock_i);
      chk(reg_rdata_o, exp);
   endtask
   task automatic drv(input int s, input logic l);
      @(posedge clock_i);
      lvl[s] <= l;
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rc(OFF_IRQ_ENABLE, ENABLE_RST);
      rc(OFF_IRQ_LATCHED, LATCHED_RST);
      rc(OFF_IRQ_POLAR, POLAR_RST);
      rc(8'h5C, READ_NONE);
      for (int i = 0; i < 4; i++) begin
         v = xs();
         wr(OFF_IRQ_ENABLE, v);
         rc(OFF_IRQ_ENABLE, v & ~RESERVED_SRC);
         wr(OFF_IRQ_POLAR, ~v);
         rc(OFF_IRQ_POLAR, ~v & ~RESERVED_SRC);
         wr(OFF_IRQ_TRIGGER, v);
         rc(OFF_IRQ_TRIGGER, TRIGGER_ALL_EDGE);
      end
      // Direct flags and spare inputs, one source at a time
      for (int s = 0; s < 32; s++) begin
         if (s < 16 && s % 4 != 3) continue;
         v = xs();
         b = 32'h1 << s;
         p = (s == 16) || (s != 17 && v[0]);
         lint_en <= v[2];
         wr(OFF_IRQ_ENABLE, 32'h0);
         wr(OFF_IRQ_POLAR, p ? b : 32'h0);
         drv(s, !p);
         drv(s, p);
         wr(OFF_IRQ_ENABLE, b);
         rc(OFF_IRQ_LATCHED, 32'h0);
         drv(s, !p);
         rc(OFF_IRQ_LATCHED, b);
         chk(irq_o, 32'h1);
         chk(host_irq, v[2]);
         rc(OFF_SRC_LEVEL, lvl);
         wr(OFF_IRQ_LATCHED, ~b);
         rc(OFF_IRQ_LATCHED, b);
         if (v[1]) wr(OFF_IRQ_ENABLE, 32'h0);
         else wr(OFF_IRQ_LATCHED, b);
         drv(s, p);
         rc(OFF_IRQ_LATCHED, 32'h0);
         chk(irq_o, 32'h0);
      end
      // Almost flags: just short of the threshold, then on it
      wr(OFF_IRQ_POLAR, 32'h0);
      for (int c = 0; c < 4; c++) begin
         ae = 16'(xs() % 16);
         af = 16'(xs() % 16);
         e = 32'h0;
         wr(OFF_TX_ALMOST + 8'(16 * c), {af, ae});
         wr(OFF_RX_ALMOST + 8'(16 * c), {af, ae});
         wr(OFF_IRQ_ENABLE, 32'h6 << (4 * c));
         for (int k = 0; k < 2; k++) begin
            @(posedge clock_i);
            txc[c] <= ae + 16'(1 - k);
            rxc[c] <= 16'(DEPTH) - af - 16'(1 - k);
            @(posedge clock_i);
            e = e | (32'(ae_f(ae + 16'(1 - k), ae)) << (4 * c + 1));
            e = e | (32'(af_f(16'(DEPTH) - af - 16'(1 - k), af)) << (4 * c + 2));
            rc(OFF_IRQ_LATCHED, e);
         end
         wr(OFF_IRQ_ENABLE, 32'h0);
         txc[c] <= 16'h0020;
         rxc[c] <= 16'h0020;
      end
      stop_test();
   end
endmodule

// *** fei_pkg.sv ***
// Constants shared by the FIFO edge interrupt controller
package fei_pkg;

   localparam int          NUM_SRC         = 32;
   localparam int          NUM_CH          = 4;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          VAL_W           = 16;

   // Register offsets
   localparam logic [7:0]  OFF_TX_ALMOST   = 8'h10;
   localparam logic [7:0]  OFF_RX_ALMOST   = 8'h14;
   localparam logic [7:0]  OFF_CH_STRIDE   = 8'h10;
   localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h60;
   localparam logic [7:0]  OFF_IRQ_LATCHED = 8'h64;
   localparam logic [7:0]  OFF_IRQ_TRIGGER = 8'h68;
   localparam logic [7:0]  OFF_IRQ_POLAR   = 8'h6C;
   localparam logic [7:0]  OFF_SRC_LEVEL   = 8'h70;

   // Almost value field positions
   localparam int          AF_LSB          = 16;
   localparam int          AE_LSB          = 0;

   // Source positions inside each group of four
   localparam int          SRC_LO_BASE     = 0;
   localparam int          SRC_HI_BASE     = 16;
   localparam int          SRC_STRIDE      = 4;

   // Reset values and fixed patterns
   localparam logic [31:0] ENABLE_RST      = 32'h0000_0000;
   localparam logic [31:0] LATCHED_RST     = 32'h0000_0000;
   localparam logic [31:0] POLAR_RST       = 32'h0000_0000;
   localparam logic [31:0] ALMOST_RST      = 32'h0000_0000;
   localparam logic [31:0] TRIGGER_ALL_EDGE = 32'hFFFF_FFFF;
   localparam logic [31:0] RESERVED_SRC    = 32'h0000_1111;
   localparam logic [31:0] READ_NONE       = 32'h0000_0000;

   // Default FIFO geometry
   localparam int          FIFO_DEPTH_DEF  = 262144;
   localparam int          CNT_W_DEF       = 19;

endpackage
